/* File: rdt_asserts.sv */
// Checker for result timing and typed decisions of the datapath
`timescale 1ns/1ps
module rdt_asserts
    import rdt_pkg::*;
#(
    parameter int unsigned DEPTH = 256,
    localparam int unsigned AW = $clog2(DEPTH)
) (
    // Clock and reset
    input wire logic sys_clk_i,
    input wire logic sys_rst_i,
    // Register ports
    input wire logic wr_en_i,
    input wire logic [AW-1:0] wr_addr_i,
    input wire logic [15:0] wr_data_i,
    input wire logic [AW-1:0] rd_addr_i,
    input wire logic [15:0] rd_data_o,
    // Instruction and result
    input wire logic op_valid_i,
    input wire logic [AW-1:0] op_addr_i,
    input wire rdt_pkg::rdt_req_type op_req_i,
    input wire logic res_valid_o,
    input wire rdt_pkg::rdt_res_type res_o
);
    // Shadow copy of the array, so decisions are judged from real contents
    logic [15:0] shadow_q [DEPTH];
    logic [AW-1:0] hi_addr;
    logic [31:0] a_dw;
    logic [15:0] b_w;
    logic ugt_w;
    logic sgt_w;
    logic dugt_w;
    logic dsgt_w;
    logic [15:0] neg_w;

    always_ff @(posedge sys_clk_i) begin
        if (wr_en_i) begin
            shadow_q[wr_addr_i] <= wr_data_i;
        end
    end

    assign hi_addr = op_addr_i + 1'b1;
    assign a_dw = {shadow_q[hi_addr], shadow_q[op_addr_i]};
    assign b_w = op_req_i.operand[15:0];
    assign ugt_w = a_dw[15:0] > b_w;
    assign sgt_w = $signed(a_dw[15:0]) > $signed(b_w);
    assign dugt_w = a_dw > op_req_i.operand;
    assign dsgt_w = $signed(a_dw) > $signed(op_req_i.operand);
    assign neg_w = ~a_dw[15:0] + 16'h0001;

    default clocking cb @(posedge sys_clk_i);
    endclocking
    default disable iff (sys_rst_i);

    sequence s_op(rdt_op_type c);
        op_valid_i && op_req_i.op == c;
    endsequence

    sequence s_wr_then_rd;
        wr_en_i && wr_addr_i == rd_addr_i ##1 $stable(rd_addr_i);
    endsequence

    a_res_pulse: assert property (op_valid_i |=> res_valid_o)
        else $error("result strobe missing after instruction");
    a_no_spurious: assert property (!op_valid_i |=> !res_valid_o)
        else $error("result strobe without instruction");
    a_res_hold: assert property (!op_valid_i |=> $stable(res_o))
        else $error("result changed while idle");
    a_ugt_word: assert property (s_op(RDT_OP_UGT)
        |=> res_o.decision == $past(ugt_w)) else $error("unsigned compare wrong");
    a_sgt_word: assert property (s_op(RDT_OP_SGT)
        |=> res_o.decision == $past(sgt_w)) else $error("signed compare wrong");
    a_dugt_pair: assert property (s_op(RDT_OP_DUGT)
        |=> res_o.decision == $past(dugt_w)) else $error("double compare wrong");
    a_dsgt_pair: assert property (s_op(RDT_OP_DSGT)
        |=> res_o.decision == $past(dsgt_w)) else $error("double signed wrong");
    a_neg_invert: assert property (s_op(RDT_OP_NEG)
        |=> res_o.data == {16'h0000, $past(neg_w)}) else $error("negate wrong");
    a_rd_copy: assert property (s_wr_then_rd
        |=> rd_data_o == $past(wr_data_i, 2)) else $error("read copy wrong");
endmodule

bind rdt_datapath rdt_asserts #(.DEPTH(DEPTH)) u_rdt_asserts (
    .sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i), .wr_en_i(wr_en_i),
    .wr_addr_i(wr_addr_i), .wr_data_i(wr_data_i), .rd_addr_i(rd_addr_i),
    .rd_data_o(rd_data_o), .op_valid_i(op_valid_i), .op_addr_i(op_addr_i),
    .op_req_i(op_req_i), .res_valid_o(res_valid_o), .res_o(res_o)
);

/* File: rdt_bcd_digit.sv */
// One packed BCD digit adder with decimal carry
`timescale 1ns/1ps
`include "rdt_params.svh"
module rdt_bcd_digit (
    // Digit operands
    input wire logic [3:0] a_i,
    input wire logic [3:0] b_i,
    input wire logic carry_i,
    // Digit result
    output logic [3:0] sum_o,
    output logic carry_o
);
    logic [4:0] raw;
    logic [4:0] adj;

    always_comb begin
        raw = {1'b0, a_i} + {1'b0, b_i} + {4'h0, carry_i};
        // Decimal correction keeps the digit in 0..9
        if (raw > {1'b0, `RDT_BCD_MAX_DIGIT}) begin
            adj = raw + `RDT_BCD_ADJUST;
            carry_o = 1'b1;
        end else begin
            adj = raw;
            carry_o = 1'b0;
        end
        sum_o = adj[3:0];
    end
endmodule

/* File: rdt_datapath.sv */
// Register file and typed datapath: integers, BCD and floats
`timescale 1ns/1ps
`include "rdt_params.svh"
module rdt_datapath #(
    parameter int unsigned DEPTH = `RDT_REG_DEPTH,
    localparam int unsigned AW = $clog2(DEPTH)
) (
    // Clock and reset
    input wire logic sys_clk_i,
    input wire logic sys_rst_i,
    // Register write port
    input wire logic wr_en_i,
    input wire logic [AW-1:0] wr_addr_i,
    input wire logic [15:0] wr_data_i,
    // Register read port
    input wire logic [AW-1:0] rd_addr_i,
    output logic [15:0] rd_data_o,
    // Instruction
    input wire logic op_valid_i,
    input wire logic [AW-1:0] op_addr_i,
    input wire rdt_pkg::rdt_req_type op_req_i,
    // Result
    output logic res_valid_o,
    output rdt_pkg::rdt_res_type res_o
);
    import rdt_pkg::*;

    // Plain data words; no type tag is stored with them
    logic [`RDT_WORD_W-1:0] regs_q [DEPTH];

    // Operand fetch
    logic [AW-1:0] hi_addr;
    logic dword_op;
    logic [15:0] a_lo;
    logic [15:0] a_hi;
    logic [31:0] a32;
    logic [31:0] b32;
    logic [15:0] b16;

    // Integer compare, negate and add
    logic ugt16;
    logic sgt16;
    logic ugt32;
    logic sgt32;
    logic [15:0] neg16;
    logic [31:0] neg32;
    logic [16:0] sum16;
    logic [32:0] sum32;
    logic ovf16;
    logic ovf32;

    // BCD adder chain
    logic bcd_sub;
    logic [31:0] bcd_b;
    logic [8:0] bcd_c;
    logic [31:0] bcd_sum;
    logic bcd_ok16;
    logic bcd_ok32;
    logic bcd_ok_sel;

    // Float unit
    logic fp_gt;
    logic fp_nan;
    logic [7:0] fp_exp;

    // Result
    rdt_res_type res_d;
    rdt_res_type res_q;
    logic res_valid_q;
    logic [15:0] rd_data_q;

    // Wraps at the top so any address, odd or even, may be A
    function automatic logic [AW-1:0] next_addr(input logic [AW-1:0] a);
        if (a == AW'(DEPTH - 1)) begin
            next_addr = '0;
        end else begin
            next_addr = a + AW'(1);
        end
    endfunction

    // True when the low n digits of v are all 0..9
    function automatic logic bcd_ok(input logic [31:0] v,
                                    input int unsigned n);
        bcd_ok = 1'b1;
        for (int unsigned i = 0; i < `RDT_DWORD_DIGITS; i++) begin
            if (i < n && v[i*4 +: 4] > `RDT_BCD_MAX_DIGIT) begin
                bcd_ok = 1'b0;
            end
        end
    endfunction

    // Nines complement of each digit, used for BCD subtraction
    function automatic logic [31:0] nines(input logic [31:0] v);
        for (int unsigned i = 0; i < `RDT_DWORD_DIGITS; i++) begin
            nines[i*4 +: 4] = `RDT_BCD_MAX_DIGIT - v[i*4 +: 4];
        end
    endfunction

    // Single-word results leave the high half clear
    function automatic logic [31:0] zext16(input logic [15:0] v);
        zext16 = {16'h0000, v};
    endfunction

    // Unbiased exponent widened with its sign
    function automatic logic [31:0] sext8(input logic [7:0] v);
        sext8 = {{24{v[7]}}, v};
    endfunction

    // Subtract forms share the adder chain with the add forms
    function automatic logic op_is_bcd_sub(input rdt_op_type op);
        op_is_bcd_sub = (op == RDT_OP_BSUB) || (op == RDT_OP_DBSUB);
    endfunction

    // Instructions that read the register pair A+1, A
    function automatic logic op_is_double(input rdt_op_type op);
        case (op)
            RDT_OP_DUGT,
            RDT_OP_DSGT,
            RDT_OP_FGT,
            RDT_OP_DNEG,
            RDT_OP_DADD,
            RDT_OP_DBADD,
            RDT_OP_DBSUB,
            RDT_OP_FEXP: begin
                op_is_double = 1'b1;
            end
            default: begin
                op_is_double = 1'b0;
            end
        endcase
    endfunction

    // Register file write
    // No reset on the array; contents stand undefined until written
    always_ff @(posedge sys_clk_i) begin
        if (wr_en_i) begin
            regs_q[wr_addr_i] <= wr_data_i;
        end
    end

    // Register file read for software-style inspection
    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            rd_data_q <= `RDT_RD_RST;
        end else begin
            rd_data_q <= regs_q[rd_addr_i];
        end
    end

    // Operand fetch: A is the low half, A+1 the high half
    always_comb begin
        dword_op = op_is_double(op_req_i.op);
        hi_addr = next_addr(op_addr_i);
        a_lo = regs_q[op_addr_i];
        // Single-word forms never look at A+1, so an unwritten
        // neighbour cannot leak into their flags
        a_hi = dword_op ? regs_q[hi_addr] : 16'h0000;
        a32 = {a_hi, a_lo};
        b32 = op_req_i.operand;
        b16 = b32[15:0];
    end

    // Integer compares, same bits read two ways
    always_comb begin
        ugt16 = a_lo > b16;
        sgt16 = $signed(a_lo) > $signed(b16);
        ugt32 = a32 > b32;
        sgt32 = $signed(a32) > $signed(b32);
    end

    // Negation and binary add
    always_comb begin
        neg16 = ~a_lo + `RDT_ONE16;
        neg32 = ~a32 + `RDT_ONE32;
        sum16 = {1'b0, a_lo} + {1'b0, b16};
        sum32 = {1'b0, a32} + {1'b0, b32};
        ovf16 = (a_lo[15] == b16[15]) && (sum16[15] != a_lo[15]);
        ovf32 = (a32[31] == b32[31]) && (sum32[31] != a32[31]);
    end

    // BCD adder chain: subtraction adds the nines complement plus one
    always_comb begin
        bcd_sub = op_is_bcd_sub(op_req_i.op);
        bcd_b = bcd_sub ? nines(b32) : b32;
        bcd_ok16 = bcd_ok(a32, `RDT_WORD_DIGITS) &&
                   bcd_ok(b32, `RDT_WORD_DIGITS);
        bcd_ok32 = bcd_ok(a32, `RDT_DWORD_DIGITS) &&
                   bcd_ok(b32, `RDT_DWORD_DIGITS);
        bcd_ok_sel = dword_op ? bcd_ok32 : bcd_ok16;
    end

    // Subtract enters the chain with a carry in: nines complement plus one
    assign bcd_c[0] = bcd_sub;

    // Eight digit cells; single-word forms use only the low four
    for (genvar g = 0; g < `RDT_DWORD_DIGITS; g++) begin : g_bcd
        rdt_bcd_digit u_digit (
            .a_i(a32[g*4 +: 4]),
            .b_i(bcd_b[g*4 +: 4]),
            .carry_i(bcd_c[g]),
            .sum_o(bcd_sum[g*4 +: 4]),
            .carry_o(bcd_c[g+1])
        );
    end

    // Float compare on the same two-register pair
    rdt_fp_cmp u_fp (
        .a_i(a32),
        .b_i(b32),
        .gt_o(fp_gt),
        .nan_o(fp_nan),
        .exp_o(fp_exp)
    );

    // Result select by instruction type
    always_comb begin
        res_d = '0;
        case (op_req_i.op)
            RDT_OP_UGT: begin
                res_d.decision = ugt16;
            end
            RDT_OP_SGT: begin
                res_d.decision = sgt16;
            end
            RDT_OP_DUGT: begin
                res_d.decision = ugt32;
            end
            RDT_OP_DSGT: begin
                res_d.decision = sgt32;
            end
            RDT_OP_FGT: begin
                res_d.decision = fp_gt;
                res_d.fp_nan = fp_nan;
            end
            RDT_OP_NEG: begin
                res_d.data = zext16(neg16);
                // Only the most negative value has no positive twin
                res_d.overflow = (a_lo == 16'h8000);
            end
            RDT_OP_DNEG: begin
                res_d.data = neg32;
                res_d.overflow = (a32 == 32'h8000_0000);
            end
            RDT_OP_ADD: begin
                res_d.data = zext16(sum16[15:0]);
                res_d.carry = sum16[16];
                res_d.overflow = ovf16;
            end
            RDT_OP_DADD: begin
                res_d.data = sum32[31:0];
                res_d.carry = sum32[32];
                res_d.overflow = ovf32;
            end
            RDT_OP_BADD,
            RDT_OP_BSUB: begin
                res_d.data = zext16(bcd_sum[15:0]);
                // For subtract the carry means no borrow
                res_d.carry = bcd_c[4];
                res_d.bcd_err = !bcd_ok_sel;
            end
            RDT_OP_DBADD,
            RDT_OP_DBSUB: begin
                res_d.data = bcd_sum;
                res_d.carry = bcd_c[8];
                res_d.bcd_err = !bcd_ok_sel;
            end
            RDT_OP_BGT: begin
                // Packed BCD orders like its binary pattern
                res_d.decision = ugt16 && bcd_ok16;
                res_d.bcd_err = !bcd_ok16;
            end
            RDT_OP_FEXP: begin
                res_d.data = sext8(fp_exp);
                res_d.fp_nan = fp_nan;
            end
            RDT_OP_NOP: begin
                res_d = '0;
            end
            default: begin
                res_d = '0;
            end
        endcase
    end

    // Result register; holds its last value between instructions
    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            res_q.data <= `RDT_RES_RST;
            res_q.decision <= 1'b0;
            res_q.carry <= 1'b0;
            res_q.overflow <= 1'b0;
            res_q.bcd_err <= 1'b0;
            res_q.fp_nan <= 1'b0;
        end else if (op_valid_i) begin
            res_q <= res_d;
        end
    end

    // One strobe per taken instruction, never stretched
    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            res_valid_q <= 1'b0;
        end else begin
            res_valid_q <= op_valid_i;
        end
    end

    assign res_o = res_q;
    assign res_valid_o = res_valid_q;
    assign rd_data_o = rd_data_q;
endmodule

/* File: rdt_datapath_test.sv */
// Self-checking bench for the typed register datapath
`timescale 1ns/1ps
module rdt_datapath_test;
    import rdt_pkg::*;
    logic sys_clk_i = 1'b0;
    logic sys_rst_i = 1'b1;
    logic wr_en_i = 1'b0;
    logic [7:0] wr_addr_i = 8'h00;
    logic [15:0] wr_data_i = 16'h0000;
    logic [7:0] rd_addr_i = 8'h00;
    logic [15:0] rd_data_o;
    logic op_valid_i = 1'b0;
    logic [7:0] op_addr_i = 8'h00;
    rdt_req_type op_req_i = '0;
    logic res_valid_o;
    rdt_res_type res_o;
    int n_errors = 0;
    int n_tests = 0;
    int cyc = 0;

    rdt_datapath #(.DEPTH(256)) u_rdt_datapath (
        .sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i), .wr_en_i(wr_en_i),
        .wr_addr_i(wr_addr_i), .wr_data_i(wr_data_i), .rd_addr_i(rd_addr_i),
        .rd_data_o(rd_data_o), .op_valid_i(op_valid_i), .op_addr_i(op_addr_i),
        .op_req_i(op_req_i), .res_valid_o(res_valid_o), .res_o(res_o)
    );

    initial begin
        forever #12.5 sys_clk_i = ~sys_clk_i;
    end

    task automatic test_done();
        $display("tests %0d errors %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_errors++;
            $display("mismatch at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask

    task automatic w(input logic [7:0] a, input logic [15:0] d);
        @(posedge sys_clk_i);
        wr_en_i <= 1'b1;
        wr_addr_i <= a;
        wr_data_i <= d;
        @(posedge sys_clk_i);
        wr_en_i <= 1'b0;
    endtask

    // Issues one instruction and samples the strobe once it has landed
    task automatic r(input logic [7:0] a, input rdt_op_type c,
                     input logic [31:0] b);
        @(posedge sys_clk_i);
        op_valid_i <= 1'b1;
        op_addr_i <= a;
        op_req_i <= {c, b};
        @(posedge sys_clk_i);
        op_valid_i <= 1'b0;
        #1;
        chk({31'h0, res_valid_o}, 32'h1);
    endtask

    task automatic t_word();
        w(8'h01, 16'hFFFF);
        rd_addr_i <= 8'h01;
        @(posedge sys_clk_i);
        @(posedge sys_clk_i);
        #1;
        chk({16'h0, rd_data_o}, 32'h0000_FFFF);
        r(8'h01, RDT_OP_UGT, 32'h0000_0064);
        chk({31'h0, res_o.decision}, 32'h1);
        r(8'h01, RDT_OP_SGT, 32'h0000_0064);
        chk({31'h0, res_o.decision}, 32'h0);
        r(8'h01, RDT_OP_SGT, 32'h0000_FFFE);
        chk({31'h0, res_o.decision}, 32'h1);
        r(8'h01, RDT_OP_NOP, 32'h0);
        w(8'h02, 16'h7FFF);
        r(8'h02, RDT_OP_ADD, 32'h1);
        chk(res_o.data, 32'h0000_8000);
    endtask

    task automatic t_neg();
        w(8'h03, 16'h7FFF);
        r(8'h03, RDT_OP_NEG, 32'h0);
        chk(res_o.data, 32'h0000_8001);
        w(8'h03, 16'h8000);
        r(8'h03, RDT_OP_NEG, 32'h0);
        chk({31'h0, res_o.overflow}, 32'h1);
        w(8'h04, 16'h0000);
        w(8'h05, 16'h0001);
        r(8'h04, RDT_OP_DNEG, 32'h0);
        chk(res_o.data, 32'hFFFF_0000);
    endtask

    // Mid-run reset clears the results but keeps the registers
    task automatic t_reset();
        r(8'h03, RDT_OP_NEG, 32'h0000_0000);
        @(posedge sys_clk_i);
        sys_rst_i <= 1'b1;
        repeat (2) @(posedge sys_clk_i);
        sys_rst_i <= 1'b0;
        rd_addr_i <= 8'h0C;
        #1;
        chk(res_o.data, 32'h0000_0000);
        chk({31'h0, res_valid_o}, 32'h0);
        chk({16'h0, rd_data_o}, 32'h0);
        w(8'h0C, 16'h1234);
        r(8'h03, RDT_OP_UGT, 32'h0000_7FFF);
        chk({31'h0, res_o.decision}, 32'h1);
        chk({16'h0, rd_data_o}, 32'h0000_1234);
        r(8'h03, RDT_OP_SGT, 32'h0000_7FFF);
        chk({31'h0, res_o.decision}, 32'h0);
    endtask

    // Odd low address and the wrap of A+1 back to register zero
    task automatic t_double();
        w(8'h05, 16'hFFFF);
        w(8'h06, 16'h7FFF);
        r(8'h05, RDT_OP_DUGT, 32'h8000_0000);
        chk({31'h0, res_o.decision}, 32'h0);
        r(8'h05, RDT_OP_DSGT, 32'h8000_0000);
        chk({31'h0, res_o.decision}, 32'h1);
        r(8'h05, RDT_OP_DADD, 32'h1);
        chk(res_o.data, 32'h8000_0000);
        w(8'hFF, 16'h0000);
        w(8'h00, 16'h0001);
        r(8'hFF, RDT_OP_DUGT, 32'h0000_FFFF);
        chk({31'h0, res_o.decision}, 32'h1);
    endtask

    task automatic t_bcd();
        w(8'h07, 16'h0999);
        r(8'h07, RDT_OP_BADD, 32'h1);
        chk(res_o.data, 32'h0000_1000);
        w(8'h07, 16'h9999);
        r(8'h07, RDT_OP_BADD, 32'h1);
        chk({res_o.data[30:0], res_o.carry}, 32'h1);
        w(8'h07, 16'h0000);
        r(8'h07, RDT_OP_BSUB, 32'h1);
        chk({res_o.data[30:0], res_o.carry}, 32'h1_3332);
        w(8'h07, 16'h0010);
        r(8'h07, RDT_OP_BGT, 32'h0009);
        chk({31'h0, res_o.decision}, 32'h1);
        w(8'h07, 16'h000A);
        r(8'h07, RDT_OP_BADD, 32'h1);
        chk({31'h0, res_o.bcd_err}, 32'h1);
        w(8'h08, 16'h9999);
        w(8'h09, 16'h9999);
        r(8'h08, RDT_OP_DBADD, 32'h1);
        chk(res_o.data, 32'h0000_0000);
        r(8'h08, RDT_OP_DBSUB, 32'h1);
        chk(res_o.data, 32'h9999_9998);
    endtask

    task automatic t_float();
        w(8'h0A, 16'h0000);
        w(8'h0B, 16'h3F80);
        r(8'h0A, RDT_OP_FGT, 32'h4000_0000);
        chk({31'h0, res_o.decision}, 32'h0);
        r(8'h0A, RDT_OP_FGT, 32'hBF80_0000);
        chk({31'h0, res_o.decision}, 32'h1);
        r(8'h0A, RDT_OP_FEXP, 32'h0);
        chk(res_o.data, 32'h0000_0000);
        w(8'h0A, 16'hFFFF);
        w(8'h0B, 16'h7F7F);
        r(8'h0A, RDT_OP_FGT, 32'h7F7F_FFFE);
        chk({31'h0, res_o.decision}, 32'h1);
        r(8'h0A, RDT_OP_FEXP, 32'h0);
        chk(res_o.data, 32'h0000_007F);
        w(8'h0B, 16'h7FC0);
        r(8'h0A, RDT_OP_FGT, 32'h0);
        chk({30'h0, res_o.fp_nan, res_o.decision}, 32'h2);
    endtask

    always @(posedge sys_clk_i) begin
        cyc++;
        if (cyc == 3000) begin
            n_errors++;
            test_done();
        end
    end

    initial begin
        repeat (5) @(posedge sys_clk_i);
        sys_rst_i <= 1'b0;
        #1;
        chk(res_o.data, 32'h0000_0000);
        chk({15'h0, res_valid_o, rd_data_o}, 32'h0000_0000);
        t_word();
        t_neg();
        t_reset();
        t_double();
        t_bcd();
        t_float();
        test_done();
    end
endmodule

/* File: rdt_fp_cmp.sv */
// Single precision greater-than compare and exponent unpack
`timescale 1ns/1ps
`include "rdt_params.svh"
module rdt_fp_cmp (
    // Operands
    input wire logic [31:0] a_i,
    input wire logic [31:0] b_i,
    // Results
    output logic gt_o,
    output logic nan_o,
    output logic [7:0] exp_o
);
    logic a_nan;
    logic b_nan;
    logic both_zero;
    logic mag_gt;
    logic mag_lt;

    function automatic logic is_nan(input logic [31:0] v);
        is_nan = (v[30:23] == `RDT_FP_EXP_MAX) && (v[22:0] != 23'h00_0000);
    endfunction

    always_comb begin
        a_nan = is_nan(a_i);
        b_nan = is_nan(b_i);
        nan_o = a_nan | b_nan;
        both_zero = (a_i[30:0] == 31'h0000_0000) &&
                    (b_i[30:0] == 31'h0000_0000);
        // Exponent and mantissa order like an unsigned magnitude
        mag_gt = a_i[30:0] > b_i[30:0];
        mag_lt = a_i[30:0] < b_i[30:0];
        gt_o = 1'b0;
        if (!nan_o && !both_zero) begin
            if (a_i[31] != b_i[31]) begin
                gt_o = !a_i[31];
            end else if (!a_i[31]) begin
                gt_o = mag_gt;
            end else begin
                gt_o = mag_lt;
            end
        end
        // Unbiased exponent, two's complement
        exp_o = a_i[30:23] - `RDT_FP_BIAS;
    end
endmodule

/* File: rdt_params.svh */
// Constants for the register data type datapath
`ifndef RDT_PARAMS_SVH
`define RDT_PARAMS_SVH

`define RDT_WORD_W 16
`define RDT_DWORD_W 32
`define RDT_NIBBLE_W 4
`define RDT_WORD_DIGITS 4
`define RDT_DWORD_DIGITS 8
`define RDT_REG_DEPTH 256
`define RDT_BCD_MAX_DIGIT 4'h9
`define RDT_BCD_ADJUST 5'h06
`define RDT_ONE16 16'h0001
`define RDT_ONE32 32'h0000_0001
`define RDT_FP_EXP_W 8
`define RDT_FP_MAN_W 23
`define RDT_FP_BIAS 8'h7F
`define RDT_FP_EXP_MAX 8'hFF
`define RDT_RES_RST 32'h0000_0000
`define RDT_RD_RST 16'h0000

`endif

/* File: rdt_pkg.sv */
// Types shared by the register data type datapath
package rdt_pkg;

    typedef enum logic [3:0] {
        RDT_OP_NOP     = 4'b0000,
        RDT_OP_UGT     = 4'b0001,
        RDT_OP_SGT     = 4'b0010,
        RDT_OP_DUGT    = 4'b0011,
        RDT_OP_DSGT    = 4'b0100,
        RDT_OP_FGT     = 4'b0101,
        RDT_OP_NEG     = 4'b0110,
        RDT_OP_DNEG    = 4'b0111,
        RDT_OP_ADD     = 4'b1000,
        RDT_OP_DADD    = 4'b1001,
        RDT_OP_BADD    = 4'b1010,
        RDT_OP_BSUB    = 4'b1011,
        RDT_OP_DBADD   = 4'b1100,
        RDT_OP_DBSUB   = 4'b1101,
        RDT_OP_BGT     = 4'b1110,
        RDT_OP_FEXP    = 4'b1111
    } rdt_op_type;

    typedef struct packed {
        rdt_op_type op;
        logic [31:0] operand;
    } rdt_req_type;

    typedef struct packed {
        logic [31:0] data;
        logic decision;
        logic carry;
        logic overflow;
        logic bcd_err;
        logic fp_nan;
    } rdt_res_type;

endpackage
